/* hdl/mgr_pkg.sv */
// Shared constants and types of the magnetometer register and control block.
package mgr_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OUT_X_HI  = 8'h01;
    localparam logic [7:0] ADDR_OUT_X_LO  = 8'h02;
    localparam logic [7:0] ADDR_OUT_Y_HI  = 8'h03;
    localparam logic [7:0] ADDR_OUT_Y_LO  = 8'h04;
    localparam logic [7:0] ADDR_OUT_Z_HI  = 8'h05;
    localparam logic [7:0] ADDR_OUT_Z_LO  = 8'h06;
    localparam logic [7:0] ADDR_IDENTITY  = 8'h07;
    localparam logic [7:0] ADDR_STATE     = 8'h08;
    localparam logic [7:0] ADDR_BIAS_X_HI = 8'h09;
    localparam logic [7:0] ADDR_BIAS_X_LO = 8'h0A;
    localparam logic [7:0] ADDR_BIAS_Y_HI = 8'h0B;
    localparam logic [7:0] ADDR_BIAS_Y_LO = 8'h0C;
    localparam logic [7:0] ADDR_BIAS_Z_HI = 8'h0D;
    localparam logic [7:0] ADDR_BIAS_Z_LO = 8'h0E;
    localparam logic [7:0] ADDR_TEMP      = 8'h0F;
    localparam logic [7:0] ADDR_CTRL      = 8'h10;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  STATE_RESET     = 8'h00;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [1:0]  SYS_STANDBY     = 2'h0;
    localparam logic [1:0]  SYS_ACTIVE_RAW  = 2'h1;
    localparam logic [1:0]  SYS_ACTIVE_CORR = 2'h2;
    localparam logic [14:0] BIAS_RESET      = 15'h0000;
    localparam logic [15:0] FIELD_RESET     = 16'h0000;
    localparam int          TRIG_BIT        = 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 10;
    localparam int BASE_PERIOD_NS     = 12_500_000;
    localparam int BASE_PERIOD_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] output_rate_select;
        logic [1:0] oversample_ratio;
        logic       fast_read_select;
        logic       measurement_trigger;
        logic       run_select;
    } mgr_ctrl_t;

    typedef logic [2:0][15:0] mgr_axes_t;
    typedef logic [2:0][14:0] mgr_bias_t;

    typedef enum logic [0:0] {
        MGR_SEQ_IDLE,
        MGR_SEQ_CONV
    } mgr_seq_t;

endpackage

/* hdl/mgr_axis_store.sv */
// Per-axis calibration, user bias subtraction and measurement output registers.
`timescale 1ns/1ps
module mgr_axis_store #(
    parameter mgr_pkg::mgr_axes_t FACTORY_TRIM = '0
) (
    // Clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_reset_n,
    // Sample in
    input  wire logic               i_load,
    input  wire logic               i_raw_mode,
    input  wire mgr_pkg::mgr_axes_t i_field,
    input  wire mgr_pkg::mgr_bias_t i_bias,
    // Stored measurement
    output mgr_pkg::mgr_axes_t      o_out
);

    mgr_pkg::mgr_axes_t out_reg;
    mgr_pkg::mgr_axes_t out_next;
    mgr_pkg::mgr_axes_t calib;

    // ------------------------------------------------------------
    // Per-axis arithmetic
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic [16:0] diff;
            assign calib[g] = i_field[g] - FACTORY_TRIM[g];
            assign diff     = {calib[g][15], calib[g]} - {{2{i_bias[g][14]}}, i_bias[g]};
            always_comb begin
                out_next[g] = out_reg[g];
                if (i_load) begin
                    if (i_raw_mode) begin
                        out_next[g] = calib[g];
                    end else begin
                        out_next[g] = diff[15:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_reg <= '0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign o_out = out_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RAW_PASS: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_load && i_raw_mode |=> out_reg[0] == $past(i_field[0]) - FACTORY_TRIM[0])
        else $error("raw sample altered by bias");
    AST_CORR_SUB: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_load && !i_raw_mode |=> out_reg[1] == 16'($past(calib[1]) - {$past(i_bias[1][14]), $past(i_bias[1])}))
        else $error("corrected sample does not subtract bias");

endmodule

/* hdl/mgr_top.sv */
// Register file, measurement sequencer and readout control of the magnetometer.
// How it works
// - Identity register is read-only with a fixed value writes cannot change.
// - State register reports standby, active raw or active corrected; upper bits zero.
// - Each axis bias is 15 bits, high byte bits 14:7, low byte bits 6:0 in its bits 7:1.
// - Corrected mode subtracts each axis bias before storing the measurement.
// - Corrected result is not clipped; it wraps within sixteen bits.
// - Raw mode stores measurements without bias subtraction.
// - Stored bias bit zero always reads zero.
// - Factory trim is always applied and is not reachable by the host.
// - Die temperature is a read-only signed byte.
// - Control holds rate 7:5, oversample 4:3, fast 2, trigger 1, run 0, reset zero.
// - Fast read auto-increment walks high bytes only; slow read walks full words.
// - Trigger while active waits for the running measurement, then measures.
// - Trigger in standby measures at once, then returns to standby.
// - Run set measures periodically at the chosen interval; cleared stays in standby.
// - Oversample codes give ratios 1, 2, 4, 8 dividing the base rate.
// - Rate codes halve 80 Hz downward; slowest combination is 0.08 Hz.
// - Each axis output is a signed 16-bit word, high byte then low.
// - Raw select low applies biases; high leaves them out.
// - Fast read auto-increment skips the low output bytes.
`timescale 1ns/1ps
module mgr_top #(
    parameter logic [7:0]         CHIP_ID_VALUE      = 8'h5A,  // Value is arbitrary.
    parameter int                 BASE_PERIOD_CYCLES = mgr_pkg::BASE_PERIOD_CYCLES,
    parameter mgr_pkg::mgr_axes_t FACTORY_TRIM       = '0
) (
    // Clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_reset_n,
    // Register access
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    input  wire logic [7:0]         i_reg_addr,
    input  wire logic [7:0]         i_reg_wdata,
    output logic [7:0]              o_reg_rdata,
    output logic [7:0]              o_next_addr,
    // Correction select
    input  wire logic               i_raw_mode,
    // Converter
    output logic                    o_conv_start,
    output logic [1:0]              o_conv_osr,
    input  wire logic               i_conv_done,
    input  wire mgr_pkg::mgr_axes_t i_conv_field,
    input  wire logic [7:0]         i_chip_temperature
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mgr_pkg::mgr_ctrl_t ctrl_reg;
    mgr_pkg::mgr_ctrl_t ctrl_next;
    mgr_pkg::mgr_ctrl_t wctrl;
    mgr_pkg::mgr_bias_t bias_reg;
    mgr_pkg::mgr_bias_t bias_next;
    mgr_pkg::mgr_seq_t  seq_reg;
    mgr_pkg::mgr_seq_t  seq_next;
    mgr_pkg::mgr_axes_t out_field;
    logic [1:0]         state_reg;
    logic [1:0]         state_next;
    logic [7:0]         temp_reg;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;
    logic [7:0]         naddr_reg;
    logic [7:0]         naddr_next;
    logic [31:0]        cnt_reg;
    logic [31:0]        cnt_next;
    logic [31:0]        interval;
    logic [3:0]         shift;
    logic               trig_conv_reg;
    logic               trig_conv_next;
    logic               start_reg;
    logic               start_next;
    logic               tick;
    logic               done;
    logic               trig_done;
    logic               ctrl_wr;
    logic               single_busy;

    assign ctrl_wr   = i_reg_wr && (i_reg_addr == mgr_pkg::ADDR_CTRL);
    assign wctrl     = mgr_pkg::mgr_ctrl_t'(i_reg_wdata);
    assign done      = (seq_reg == mgr_pkg::MGR_SEQ_CONV) && i_conv_done;
    assign trig_done = done && trig_conv_reg;

    // ------------------------------------------------------------
    // Control and bias registers
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        bias_next = bias_reg;
        if (ctrl_wr) begin
            if (state_reg == mgr_pkg::SYS_STANDBY) begin
                ctrl_next = wctrl;
            end else begin
                ctrl_next.measurement_trigger = wctrl.measurement_trigger;
                ctrl_next.run_select          = wctrl.run_select;
            end
        end
        if (trig_done && !(ctrl_wr && i_reg_wdata[mgr_pkg::TRIG_BIT])) begin
            ctrl_next.measurement_trigger = 1'b0;
        end
        if (i_reg_wr) begin
            if (i_reg_addr == mgr_pkg::ADDR_BIAS_X_HI) begin
                bias_next[0][14:7] = i_reg_wdata;
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_X_LO) begin
                bias_next[0][6:0] = i_reg_wdata[7:1];
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Y_HI) begin
                bias_next[1][14:7] = i_reg_wdata;
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Y_LO) begin
                bias_next[1][6:0] = i_reg_wdata[7:1];
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Z_HI) begin
                bias_next[2][14:7] = i_reg_wdata;
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Z_LO) begin
                bias_next[2][6:0] = i_reg_wdata[7:1];
            end
        end
    end

    // ------------------------------------------------------------
    // Measurement interval and sequencer
    // ------------------------------------------------------------
    assign shift    = {1'b0, ctrl_reg.output_rate_select} + {2'b00, ctrl_reg.oversample_ratio};
    assign interval = 32'(BASE_PERIOD_CYCLES) << shift;
    assign tick     = ctrl_reg.run_select && (cnt_reg == interval - 32'h0000_0001);
    assign single_busy = (seq_reg == mgr_pkg::MGR_SEQ_CONV) && trig_conv_reg && !ctrl_reg.run_select;

    always_comb begin
        cnt_next       = cnt_reg + 32'h0000_0001;
        seq_next       = seq_reg;
        trig_conv_next = trig_conv_reg;
        start_next     = 1'b0;
        if (!ctrl_reg.run_select || tick) begin
            cnt_next = 32'h0000_0000;
        end
        case (seq_reg)
            mgr_pkg::MGR_SEQ_IDLE: begin
                if (ctrl_reg.measurement_trigger) begin
                    seq_next       = mgr_pkg::MGR_SEQ_CONV;
                    trig_conv_next = 1'b1;
                    start_next     = 1'b1;
                end else if (tick) begin
                    seq_next       = mgr_pkg::MGR_SEQ_CONV;
                    trig_conv_next = 1'b0;
                    start_next     = 1'b1;
                end
            end
            mgr_pkg::MGR_SEQ_CONV: begin
                if (i_conv_done) begin
                    seq_next       = mgr_pkg::MGR_SEQ_IDLE;
                    trig_conv_next = 1'b0;
                end
            end
            default: begin
                seq_next = mgr_pkg::MGR_SEQ_IDLE;
            end
        endcase
        if (ctrl_reg.run_select || single_busy) begin
            state_next = i_raw_mode ? mgr_pkg::SYS_ACTIVE_RAW : mgr_pkg::SYS_ACTIVE_CORR;
        end else begin
            state_next = mgr_pkg::SYS_STANDBY;
        end
    end

    // ------------------------------------------------------------
    // Read data and auto-increment
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = rdata_reg;
        naddr_next = naddr_reg;
        if (i_reg_rd) begin
            if (i_reg_addr == mgr_pkg::ADDR_OUT_X_HI) begin
                rdata_next = out_field[0][15:8];
            end else if (i_reg_addr == mgr_pkg::ADDR_OUT_X_LO) begin
                rdata_next = out_field[0][7:0];
            end else if (i_reg_addr == mgr_pkg::ADDR_OUT_Y_HI) begin
                rdata_next = out_field[1][15:8];
            end else if (i_reg_addr == mgr_pkg::ADDR_OUT_Y_LO) begin
                rdata_next = out_field[1][7:0];
            end else if (i_reg_addr == mgr_pkg::ADDR_OUT_Z_HI) begin
                rdata_next = out_field[2][15:8];
            end else if (i_reg_addr == mgr_pkg::ADDR_OUT_Z_LO) begin
                rdata_next = out_field[2][7:0];
            end else if (i_reg_addr == mgr_pkg::ADDR_IDENTITY) begin
                rdata_next = CHIP_ID_VALUE;
            end else if (i_reg_addr == mgr_pkg::ADDR_STATE) begin
                rdata_next = {6'h00, state_reg};
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_X_HI) begin
                rdata_next = bias_reg[0][14:7];
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_X_LO) begin
                rdata_next = {bias_reg[0][6:0], 1'b0};
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Y_HI) begin
                rdata_next = bias_reg[1][14:7];
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Y_LO) begin
                rdata_next = {bias_reg[1][6:0], 1'b0};
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Z_HI) begin
                rdata_next = bias_reg[2][14:7];
            end else if (i_reg_addr == mgr_pkg::ADDR_BIAS_Z_LO) begin
                rdata_next = {bias_reg[2][6:0], 1'b0};
            end else if (i_reg_addr == mgr_pkg::ADDR_TEMP) begin
                rdata_next = temp_reg;
            end else if (i_reg_addr == mgr_pkg::ADDR_CTRL) begin
                rdata_next = ctrl_reg;
            end else begin
                rdata_next = mgr_pkg::BYTE_ZERO;
            end
        end
        if (i_reg_rd || i_reg_wr) begin
            if (ctrl_reg.fast_read_select && (i_reg_addr == mgr_pkg::ADDR_OUT_X_HI ||
                i_reg_addr == mgr_pkg::ADDR_OUT_Y_HI || i_reg_addr == mgr_pkg::ADDR_OUT_Z_HI)) begin
                naddr_next = i_reg_addr + 8'h02;
            end else begin
                naddr_next = i_reg_addr + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg      <= mgr_pkg::CTRL_RESET;
            bias_reg      <= {3{mgr_pkg::BIAS_RESET}};
            seq_reg       <= mgr_pkg::MGR_SEQ_IDLE;
            state_reg     <= mgr_pkg::SYS_STANDBY;
            temp_reg      <= mgr_pkg::BYTE_ZERO;
            rdata_reg     <= mgr_pkg::BYTE_ZERO;
            naddr_reg     <= mgr_pkg::BYTE_ZERO;
            cnt_reg       <= 32'h0000_0000;
            trig_conv_reg <= 1'b0;
            start_reg     <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            bias_reg      <= bias_next;
            seq_reg       <= seq_next;
            state_reg     <= state_next;
            temp_reg      <= i_chip_temperature;
            rdata_reg     <= rdata_next;
            naddr_reg     <= naddr_next;
            cnt_reg       <= cnt_next;
            trig_conv_reg <= trig_conv_next;
            start_reg     <= start_next;
        end
    end

    // ------------------------------------------------------------
    // Measurement store
    // ------------------------------------------------------------
    mgr_axis_store #(
        .FACTORY_TRIM (FACTORY_TRIM)
    ) u_store (
        .i_ref_clk  (i_ref_clk),
        .i_reset_n  (i_reset_n),
        .i_load     (done),
        .i_raw_mode (i_raw_mode),
        .i_field    (i_conv_field),
        .i_bias     (bias_reg),
        .o_out      (out_field)
    );

    assign o_reg_rdata  = rdata_reg;
    assign o_next_addr  = naddr_reg;
    assign o_conv_start = start_reg;
    assign o_conv_osr   = ctrl_reg.oversample_ratio;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_ID_FIXED: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_reg_rd && i_reg_addr == mgr_pkg::ADDR_IDENTITY |=> o_reg_rdata == CHIP_ID_VALUE)
        else $error("identity read wrong");
    AST_STATE_CODE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_reg_rd && i_reg_addr == mgr_pkg::ADDR_STATE |=> o_reg_rdata[7:2] == 6'h00 && o_reg_rdata[1:0] != 2'h3)
        else $error("state register code illegal");
    AST_BIAS_LSB: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_reg_rd && (i_reg_addr == mgr_pkg::ADDR_BIAS_X_LO || i_reg_addr == mgr_pkg::ADDR_BIAS_Z_LO)
        |=> o_reg_rdata[0] == 1'b0)
        else $error("bias low bit not zero");
    AST_FAST_SKIP: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_reg_rd && ctrl_reg.fast_read_select && i_reg_addr == mgr_pkg::ADDR_OUT_Y_HI
        |=> o_next_addr == mgr_pkg::ADDR_OUT_Z_HI)
        else $error("fast read did not skip low byte");
    AST_TRIG_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        trig_done && !ctrl_wr |=> !ctrl_reg.measurement_trigger)
        else $error("trigger not cleared after measurement");
    AST_STANDBY_RETURN: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (single_busy && i_conv_done && !i_reg_wr) ##1 !i_reg_wr |=> ##1 state_reg == mgr_pkg::SYS_STANDBY)
        else $error("no return to standby after single measurement");
    AST_LOCKED_FIELDS: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        ctrl_wr && state_reg != mgr_pkg::SYS_STANDBY
        |=> ctrl_reg[7:2] == $past(ctrl_reg[7:2]))
        else $error("control field changed while active");
    AST_STANDBY_START: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        seq_reg == mgr_pkg::MGR_SEQ_IDLE && ctrl_reg.measurement_trigger |=> o_conv_start ##1 !o_conv_start)
        else $error("trigger did not start one measurement");
    AST_PERIODIC_START: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        seq_reg == mgr_pkg::MGR_SEQ_IDLE && tick |=> o_conv_start && cnt_reg == 32'h0000_0000)
        else $error("periodic tick did not start a measurement");
    AST_NO_RUN_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !ctrl_reg.run_select && !ctrl_reg.measurement_trigger && seq_reg == mgr_pkg::MGR_SEQ_IDLE |=> !o_conv_start)
        else $error("measurement started in standby");

    COV_SINGLE: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) single_busy && i_conv_done);
    COV_PERIODIC: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) tick ##1 o_conv_start);
    COV_FAST: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        i_reg_rd && ctrl_reg.fast_read_select && i_reg_addr == mgr_pkg::ADDR_OUT_X_HI);
    COV_TRIG_BUSY: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        seq_reg == mgr_pkg::MGR_SEQ_CONV && !trig_conv_reg && ctrl_reg.measurement_trigger);

endmodule

/* verif/mgr_conv_model.sv */
// Converter model that answers each start with a fixed three-axis field after a delay.
`timescale 1ns/1ps
module mgr_conv_model #(
    parameter int DELAY = 5
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_start,
    output logic               o_done,
    output mgr_pkg::mgr_axes_t o_field
);
    localparam mgr_pkg::mgr_axes_t FIELD = {16'h0123, 16'hF000, 16'h1000};
    int cnt = 0;
    initial o_done = 1'h0;
    initial o_field = ~FIELD;
    // The field is only valid together with done; otherwise it shows the inverse.
    always @(posedge i_ref_clk) begin
        o_done <= 1'h0;
        o_field <= ~FIELD;
        if (i_start) begin
            cnt <= DELAY;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            o_done <= (cnt == 1);
            o_field <= (cnt == 1) ? FIELD : ~FIELD;
        end
    end
endmodule

/* verif/test_magnetometer_regs_and_control.sv */
// Self-checking testbench of the magnetometer register and control block.
`timescale 1ns/1ps
module test_magnetometer_regs_and_control;
    logic               i_ref_clk, i_reset_n, i_reg_wr, i_reg_rd, i_raw_mode, o_conv_start, i_conv_done;
    logic [7:0]         i_reg_addr, i_reg_wdata, o_reg_rdata, o_next_addr, i_chip_temperature;
    logic [1:0]         o_conv_osr;
    localparam logic [7:0] TB_ID = 8'h3C;  // Value is arbitrary.
    mgr_pkg::mgr_axes_t i_conv_field;
    int                 num_errors = 0;
    int                 tests_run = 0;

    mgr_top #(.CHIP_ID_VALUE(TB_ID), .BASE_PERIOD_CYCLES(8)) dut_u (.i_ref_clk, .i_reset_n, .i_reg_wr,
        .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_next_addr, .i_raw_mode, .o_conv_start, .o_conv_osr,
        .i_conv_done, .i_conv_field, .i_chip_temperature);
    mgr_conv_model pm_u (.i_ref_clk, .i_start(o_conv_start), .o_done(i_conv_done), .o_field(i_conv_field));

    initial begin
        i_ref_clk = 1'h0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= 1'h1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_reg_rd <= 1'h1;
        i_reg_addr <= a;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'h0;
        @(posedge i_ref_clk);
        check(o_reg_rdata, exp);
    endtask

    task automatic wait_done();
        int n = 0;
        while (i_conv_done !== 1'h1 && n < 200) begin
            @(posedge i_ref_clk);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            $display("mismatch at %0t: no conversion finished", $time);
            summarize();
        end
        repeat (3) @(posedge i_ref_clk);
    endtask

    task automatic t_ident();
        rd(mgr_pkg::ADDR_IDENTITY, TB_ID);
        wr(mgr_pkg::ADDR_IDENTITY, 8'hFF);
        rd(mgr_pkg::ADDR_IDENTITY, TB_ID);
        rd(mgr_pkg::ADDR_STATE, 8'h00);
        rd(mgr_pkg::ADDR_CTRL, 8'h00);
        rd(8'h20, 8'h00);
        wr(mgr_pkg::ADDR_CTRL, 8'h18);
        @(posedge i_ref_clk);
        check({6'h00, o_conv_osr}, 8'h03);
        rd(mgr_pkg::ADDR_CTRL, 8'h18);
        wr(mgr_pkg::ADDR_CTRL, 8'h00);
    endtask

    task automatic t_bias();
        i_chip_temperature <= 8'hE7;
        wr(mgr_pkg::ADDR_BIAS_X_HI, 8'h12);
        wr(mgr_pkg::ADDR_BIAS_X_LO, 8'hFF);
        rd(mgr_pkg::ADDR_BIAS_X_HI, 8'h12);
        rd(mgr_pkg::ADDR_BIAS_X_LO, 8'hFE);
        rd(mgr_pkg::ADDR_TEMP, 8'hE7);
    endtask

    task automatic t_shot(input logic raw, input logic [7:0] x_hi, input logic [7:0] x_lo);
        i_raw_mode <= raw;
        wr(mgr_pkg::ADDR_CTRL, 8'h02);
        wait_done();
        rd(mgr_pkg::ADDR_STATE, 8'h00);
        rd(mgr_pkg::ADDR_CTRL, 8'h00);
        rd(mgr_pkg::ADDR_OUT_X_HI, x_hi);
        rd(mgr_pkg::ADDR_OUT_X_LO, x_lo);
        rd(mgr_pkg::ADDR_OUT_Y_HI, 8'hF0);
    endtask

    task automatic t_active();
        wr(mgr_pkg::ADDR_CTRL, 8'h05);
        rd(mgr_pkg::ADDR_OUT_X_HI, 8'h10);
        check(o_next_addr, 8'h03);
        rd(mgr_pkg::ADDR_OUT_Y_HI, 8'hF0);
        check(o_next_addr, 8'h05);
        rd(mgr_pkg::ADDR_OUT_X_LO, 8'h00);
        rd(mgr_pkg::ADDR_STATE, 8'h01);
        wr(mgr_pkg::ADDR_CTRL, 8'hFB);
        wait_done();
        wait_done();
        rd(mgr_pkg::ADDR_CTRL, 8'h05);
        wr(mgr_pkg::ADDR_CTRL, 8'h04);
        repeat (10) @(posedge i_ref_clk);
        rd(mgr_pkg::ADDR_STATE, 8'h00);
    endtask

    initial begin
        i_reset_n = 1'h0;
        i_reg_wr = 1'h0;
        i_reg_rd = 1'h0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_raw_mode = 1'h0;
        i_chip_temperature = 8'h19;
        repeat (16) @(posedge i_ref_clk);
        i_reset_n <= 1'h1;
        t_ident();
        t_bias();
        t_shot(1'h0, 8'h06, 8'h81);
        t_shot(1'h1, 8'h10, 8'h00);
        t_active();
        summarize();
    end
endmodule
